// ==== inc/sram_cmd_pkg.sv ====
package sram_cmd_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int ADDR_W = 21;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int BURST_W = 2;
  localparam int ROW_W = ADDR_W - BURST_W;
  localparam int BUF_DEPTH = 2;

  // ********************************************************
  // Constants
  // ********************************************************
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [LANES-1:0] LANES_NONE = 2'h3;
  localparam logic STATIC_PULL = 1'b1;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {BURST_NONE, BURST_READ, BURST_WRITE} burst_kind_e;

  typedef struct packed {
    logic chip_select_low_first;
    logic chip_select_high;
    logic chip_select_low_second;
    logic advance_or_load;
    logic read_not_write;
    logic [LANES-1:0] byte_write_enables_n;
  } cmd_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] lanes;
  } wr_beat_s;

  function automatic logic is_selected(input cmd_s c);
    return !c.chip_select_low_first && c.chip_select_high && !c.chip_select_low_second;
  endfunction : is_selected

endpackage : sram_cmd_pkg

// ==== rtl/burst_addr_gen.sv ====
module burst_addr_gen
  import sram_cmd_pkg::*;
(
  input wire logic [sram_cmd_pkg::BURST_W-1:0] start,
  input wire logic [sram_cmd_pkg::BURST_W-1:0] count,
  input wire logic interleave,
  output logic [sram_cmd_pkg::BURST_W-1:0] cur_low,
  output logic [sram_cmd_pkg::BURST_W-1:0] next_low
);

  logic [BURST_W-1:0] next_count;

  // The count is only two bits, so the fifth beat wraps home.
  assign next_count = BURST_W'(count + BURST_STEP);

  function automatic logic [BURST_W-1:0] order(input logic [BURST_W-1:0] s, input logic [BURST_W-1:0] c,
                                              input logic il);
    // [RL16] Interleaved or linear.
    return il ? (s ^ c) : BURST_W'(s + c);
  endfunction : order

  assign cur_low = order(start, count, interleave);
  assign next_low = order(start, next_count, interleave);

endmodule : burst_addr_gen

// ==== rtl/two_entry_buffer.sv ====
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0] next_fill;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  assign in_ready = (fill != FULL);
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_fill = fill;
    if (push && !pop)
    begin
      next_fill = (PW+1)'(fill + 1'b1);
    end
    else if (pop && !push)
    begin
      next_fill = (PW+1)'(fill - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  // Storage needs no reset: the fill count guards every read.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : two_entry_buffer

// ==== rtl/sync_burst_sram_cmd.sv ====
// How it works
// [RL1] Load with any chip select inactive deselects; bus stays high-impedance.
// [RL2] Selected load with read high loads address and starts a read burst.
// [RL3] Reads while output enable is high keep the bus off but still count.
// [RL4] Selected load, write low, some lane enable low: start a write burst.
// [RL5] All lane enables high on a write beat stores nothing.
// [RL6] Only lanes whose enable is low are written, sampled every beat.
// [RL7] Advance continues the burst type chosen by the loading cycle.
// [RL8] Every advance cycle increments the burst counter, aborts and dummies too.
// [RL9] Two-bit counter; the fifth beat returns to the loaded address.
// [RL10] Clock hold high freezes address and state for that edge.
// [RL11] Held cycles keep a read bus driven, a write bus off, and write nothing; pipelined, a hold right after a read-to-write turnaround drives the bus.
// [RL12] Drivers switch off by themselves on write beats.
// [RL13] Controller may tie output enable low.
// [RL14] All controls sampled at the rising edge; output enable acts asynchronously.
// [RL15] Data drivers are off from power-up until a read.
// [RL16] Order select high interleaves by XOR; low counts linearly modulo four.
// [RL17] Flow select high pipelines the output; low passes it straight through.
// [RL18] Pipelined data follows its address by one clock; flow-through same cycle.
module sync_burst_sram_cmd
  import sram_cmd_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire sram_cmd_pkg::cmd_s CMD,
  input wire logic [sram_cmd_pkg::ADDR_W-1:0] ADDR,
  input wire logic CLOCK_HOLD_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic BURST_ORDER_SELECT,
  input wire logic FLOW_THROUGH_SELECT_N,
  input wire logic [sram_cmd_pkg::DATA_W-1:0] DATA_IN,
  output logic [sram_cmd_pkg::DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_N,
  output logic WRITE_READY,
  output logic [sram_cmd_pkg::ADDR_W-1:0] MEM_RD_ADDR,
  output logic MEM_RD_EN,
  input wire logic [sram_cmd_pkg::DATA_W-1:0] MEM_RD_DATA,
  output sram_cmd_pkg::wr_beat_s MEM_WR,
  output logic MEM_WR_VALID,
  input wire logic MEM_WR_READY
);

  import sram_cmd_pkg::*;

  // ********************************************************
  // Static strap pins
  // ********************************************************
  logic order_meta;
  logic order_sync;
  logic flow_meta;
  logic flow_sync;

  // Straps float high, so reset leaves both in their pulled-up mode.
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      order_meta <= STATIC_PULL;
      order_sync <= STATIC_PULL;
      flow_meta <= STATIC_PULL;
      flow_sync <= STATIC_PULL;
    end
    else
    begin
      order_meta <= BURST_ORDER_SELECT;
      order_sync <= order_meta;
      flow_meta <= FLOW_THROUGH_SELECT_N;
      flow_sync <= flow_meta;
    end
  end

  // ********************************************************
  // Command decode
  // ********************************************************
  logic clk_en;
  logic load;
  logic sel;
  logic any_lane;

  // [RL10] Edge ignored on hold.
  assign clk_en = !CLOCK_HOLD_N;
  // [RL14] Sampled controls.
  assign load = !CMD.advance_or_load;
  assign sel = is_selected(CMD);
  assign any_lane = (CMD.byte_write_enables_n != LANES_NONE);

  // ********************************************************
  // Burst state
  // ********************************************************
  burst_kind_e kind;
  burst_kind_e next_kind;
  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] next_row;
  logic [BURST_W-1:0] start;
  logic [BURST_W-1:0] next_start;
  logic [BURST_W-1:0] count;
  logic [BURST_W-1:0] next_count;
  logic rd_beat;
  logic next_rd_beat;
  logic [BURST_W-1:0] cur_low;
  logic [BURST_W-1:0] adv_low;
  logic push;
  wr_beat_s beat;
  logic buf_ready;

  burst_addr_gen addr_gen (
    .start(start),
    .count(count),
    .interleave(order_sync),
    .cur_low(cur_low),
    .next_low(adv_low)
  );

  always_comb
  begin
    next_kind = kind;
    next_row = row;
    next_start = start;
    next_count = count;
    next_rd_beat = rd_beat;
    push = 1'b0;
    beat.addr = ADDR;
    beat.data = DATA_IN;
    beat.lanes = ~CMD.byte_write_enables_n;
    if (clk_en)
    begin
      if (load)
      begin
        next_row = ADDR[ADDR_W-1:BURST_W];
        next_start = ADDR[BURST_W-1:0];
        next_count = BURST_FIRST;
        if (!sel)
        begin
          // [RL1] Deselect cycle.
          next_kind = BURST_NONE;
          next_rd_beat = 1'b0;
        end
        else if (CMD.read_not_write)
        begin
          // [RL2] Begin read burst.
          next_kind = BURST_READ;
          next_rd_beat = 1'b1;
        end
        else
        begin
          // [RL4] Begin write burst.
          next_kind = BURST_WRITE;
          next_rd_beat = 1'b0;
          // [RL5] Abort when no lane enabled.
          push = any_lane;
        end
      end
      else
      begin
        // [RL8] Advance on every continue.
        next_count = BURST_W'(count + BURST_STEP);
        beat.addr = {row, adv_low};
        // [RL7] Keep the loaded type.
        unique case (kind)
          BURST_READ:
          begin
            next_rd_beat = 1'b1;
          end
          BURST_WRITE:
          begin
            next_rd_beat = 1'b0;
            // [RL5] Continue abort.
            push = any_lane;
          end
          BURST_NONE:
          begin
            next_rd_beat = 1'b0;
          end
          default:
          begin
            next_kind = BURST_NONE;
            next_rd_beat = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      kind <= BURST_NONE;
      row <= '0;
      start <= '0;
      count <= '0;
      rd_beat <= 1'b0;
    end
    else
    begin
      kind <= next_kind;
      row <= next_row;
      start <= next_start;
      count <= next_count;
      rd_beat <= next_rd_beat;
    end
  end

  // [RL9] Address from wrapping counter.
  assign MEM_RD_ADDR = {row, cur_low};
  assign MEM_RD_EN = rd_beat;

  // ********************************************************
  // Write path buffer
  // ********************************************************
  // [RL6] Lane mask rides with each beat.
  two_entry_buffer #(
    .WIDTH($bits(wr_beat_s)),
    .DEPTH(BUF_DEPTH)
  ) wr_buf (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(beat),
    .out_valid(MEM_WR_VALID),
    .out_ready(MEM_WR_READY),
    .out_data(MEM_WR)
  );

  // A beat offered while full is dropped, so the controller must watch this.
  assign WRITE_READY = buf_ready;

  // ********************************************************
  // Read output stage
  // ********************************************************
  logic pipe_drive;
  logic next_pipe_drive;
  logic [DATA_W-1:0] pipe_data;
  logic [DATA_W-1:0] next_pipe_data;
  logic drive;
  logic write_now;

  always_comb
  begin
    next_pipe_drive = pipe_drive;
    next_pipe_data = pipe_data;
    // [RL11] Held edge keeps the stage.
    if (clk_en)
    begin
      // [RL18] One clock of latency.
      next_pipe_drive = rd_beat;
      if (rd_beat)
      begin
        next_pipe_data = MEM_RD_DATA;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pipe_drive <= 1'b0;
      pipe_data <= '0;
    end
    else
    begin
      pipe_drive <= next_pipe_drive;
      pipe_data <= next_pipe_data;
    end
  end

  // [RL12] Write beat on the bus.
  // Write data is taken at the edge of its own command, so the drivers must yield for that whole cycle.
  assign write_now = clk_en && (load ? (sel && !CMD.read_not_write) : (kind == BURST_WRITE));

  // [RL17] Pipelined or flow-through.
  assign drive = !write_now && (flow_sync ? pipe_drive : rd_beat);
  // Flow-through trades a register for latency, so its data comes from the array.
  assign DATA_OUT = flow_sync ? pipe_data : MEM_RD_DATA;
  // [RL3] [RL12] [RL13] [RL15] Output enable gates drivers asynchronously.
  assign DATA_OE_N = !(drive && !OUTPUT_ENABLE_N);

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  a_deselect_idle: assert property (clk_en && load && !sel |=> kind == BURST_NONE && !rd_beat) // [RL1]
    else $error("Deselect did not idle the burst.");

  a_read_begin_addr: assert property (clk_en && load && sel && CMD.read_not_write // [RL2]
    |=> rd_beat && MEM_RD_ADDR == $past(ADDR))
    else $error("Read burst did not load the address.");

  a_oe_high_off: assert property (OUTPUT_ENABLE_N |-> DATA_OE_N) // [RL3]
    else $error("Bus driven while output enable high.");

  a_write_queued: assert property (clk_en && load && sel && !CMD.read_not_write && any_lane && buf_ready // [RL4]
    |=> MEM_WR_VALID)
    else $error("Write beat not queued.");

  a_abort_no_store: assert property (!any_lane |-> !push) // [RL5]
    else $error("Aborted write stored data.");

  a_lane_mask: assert property (push |-> beat.lanes == ~CMD.byte_write_enables_n && beat.data == DATA_IN) // [RL6]
    else $error("Write lanes do not match enables.");

  a_count_advance: assert property (clk_en && !load |=> count == BURST_W'($past(count) + BURST_STEP)) // [RL8]
    else $error("Counter missed an advance.");

  a_burst_wrap: assert property ((clk_en && load && sel && CMD.read_not_write) ##1 (clk_en && !load) [*4] // [RL9]
    |=> MEM_RD_ADDR == $past(MEM_RD_ADDR, 4))
    else $error("Burst did not wrap to the start.");

  a_hold_frozen: assert property (!clk_en |=> $stable(count) && $stable(kind) && $stable(pipe_drive)) // [RL10]
    else $error("State moved on a held edge.");

  a_hold_no_write: assert property (!clk_en |-> !push) // [RL11]
    else $error("Write performed on a held edge.");

  a_write_no_drive: assert property (kind == BURST_WRITE && !rd_beat && !pipe_drive |-> DATA_OE_N) // [RL12]
    else $error("Drivers on during write.");

  a_pipe_latency: assert property (clk_en && rd_beat |=> pipe_drive && pipe_data == $past(MEM_RD_DATA)) // [RL18]
    else $error("Pipelined data late or wrong.");

  a_write_cycle_off: assert property (write_now |-> DATA_OE_N) // [RL12]
    else $error("Drivers on during a write cycle.");

  a_stored_lanes: assert property (MEM_WR_VALID |-> MEM_WR.lanes != '0) // [RL5]
    else $error("Queued beat has no lane enabled.");

  a_cont_desel: assert property (clk_en && !load && kind == BURST_NONE |=> !rd_beat) // [RL1]
    else $error("Continue after deselect started a read.");

  a_flow_same_cycle: assert property (!flow_sync && rd_beat && !OUTPUT_ENABLE_N && !write_now // [RL18]
    |-> !DATA_OE_N && DATA_OUT == MEM_RD_DATA)
    else $error("Flow-through data not on the bus in its cycle.");

  a_linear_step: assert property (clk_en && !load && !order_sync // [RL16]
    |=> MEM_RD_ADDR[BURST_W-1:0] == BURST_W'($past(MEM_RD_ADDR[BURST_W-1:0]) + BURST_STEP))
    else $error("Linear burst did not step by one.");

  c_read_burst: cover property ((clk_en && load && sel && CMD.read_not_write) ##1 (clk_en && !load) [*3]);
  c_write_burst: cover property ((push && load) ##1 (push && !load) [*3]);
  c_write_abort: cover property (clk_en && kind == BURST_WRITE && !load && !any_lane);
  c_hold_read: cover property (rd_beat && !clk_en && !DATA_OE_N);
  c_flow_read: cover property (!flow_sync && rd_beat && !DATA_OE_N);

endmodule : sync_burst_sram_cmd

// ==== testbench/sram_array_model.sv ====
module sram_array_model
  import sram_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic stall,
  input wire logic [sram_cmd_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_en,
  output logic [sram_cmd_pkg::DATA_W-1:0] rd_data,
  input wire sram_cmd_pkg::wr_beat_s wr,
  input wire logic wr_valid,
  output logic wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import sram_cmd_pkg::*;
  wr_beat_s wr_q[$];
  logic phase = 1'b0;

  // ********************************************************
  // Array ports
  // ********************************************************
  // Idle read data toggles so a stale word is never mistaken for a fresh one.
  assign rd_data = rd_en ? (rd_addr[17:0] ^ 18'h2c3c3) : (18'h15555 ^ {18{phase}});
  assign wr_ready = !stall;

  always @(posedge clk)
  begin
    phase <= !phase;
    if (wr_valid && wr_ready)
      wr_q.push_back(wr);
  end
endmodule : sram_array_model

// ==== testbench/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_cmd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  cmd_s cmd = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3};
  logic [ADDR_W-1:0] addr = 21'h0;
  logic hold_n = 1'b0;
  logic oe_n = 1'b0;
  logic order = 1'b1;
  logic ft_n = 1'b1;
  logic stall = 1'b0;
  logic [DATA_W-1:0] din = 18'h0;
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] rd_data;
  logic [ADDR_W-1:0] rd_addr;
  logic doe_n;
  logic wready;
  logic rd_en;
  logic wr_valid;
  logic wr_ready;
  wr_beat_s wr;
  int errors = 0;
  int compares = 0;

  sync_burst_sram_cmd i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .CMD(cmd), .ADDR(addr), .CLOCK_HOLD_N(hold_n),
    .OUTPUT_ENABLE_N(oe_n), .BURST_ORDER_SELECT(order), .FLOW_THROUGH_SELECT_N(ft_n), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE_N(doe_n), .WRITE_READY(wready), .MEM_RD_ADDR(rd_addr), .MEM_RD_EN(rd_en),
    .MEM_RD_DATA(rd_data), .MEM_WR(wr), .MEM_WR_VALID(wr_valid), .MEM_WR_READY(wr_ready));
  sram_array_model i_mem (.clk(sys_clk), .stall(stall), .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data),
    .wr(wr), .wr_valid(wr_valid), .wr_ready(wr_ready));

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ********************************************************
  // Access tasks
  // ********************************************************
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic issue(input logic [2:0] cs, input logic adv, input logic rnw, input logic [1:0] ben,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    cmd = '{cs[2], cs[1], cs[0], adv, rnw, ben};
    addr = a;
    din = d;
    @(negedge sys_clk);
  endtask : issue

  function automatic logic [ADDR_W-1:0] beat(input logic [ADDR_W-1:0] a, input int k);
    return {a[ADDR_W-1:2], order ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0]};
  endfunction : beat

  task automatic rd_burst(input logic [ADDR_W-1:0] a, input int n, input logic hold);
    logic [ADDR_W-1:0] ea;
    logic [ADDR_W-1:0] pa;
    pa = a;
    for (int k = 0; k < n; k++)
    begin
      ea = beat(a, k);
      issue(3'h2, k != 0, 1'b1, 2'h3, a, 18'h0);
      check("rd_addr", ea, rd_addr);
      check("rd_en", 1'b1, rd_en);
      if (!ft_n) check("ft_data", ea[17:0] ^ 18'h2c3c3, dout);
      if (ft_n && k > 0 && !oe_n) check("pipe_data", pa[17:0] ^ 18'h2c3c3, dout);
      if (k > 0 || !ft_n) check("rd_drive", oe_n, doe_n);
      if (hold && k == 1)
      begin
        hold_n = 1'b1;
        @(negedge sys_clk);
        check("hold_addr", ea, rd_addr);
        check("hold_drive", 1'b0, doe_n);
        hold_n = 1'b0;
      end
      pa = ea;
    end
  endtask : rd_burst

  task automatic wr_burst(input logic [ADDR_W-1:0] a, input logic [7:0] bens, input int n, input int keep,
                          input logic hold);
    wr_beat_s exp_q[$];
    logic [1:0] ben;
    int base;
    base = i_mem.wr_q.size();
    for (int k = 0; k < n; k++)
    begin
      ben = bens[2*k +: 2];
      issue(3'h2, k != 0, 1'b0, ben, a, 18'h1c0f0 ^ 18'(k));
      if (ben != 2'h3 && exp_q.size() < keep)
        exp_q.push_back('{beat(a, k), 18'h1c0f0 ^ 18'(k), ~ben});
      check("wr_drive", 1'b1, doe_n);
      if (hold && k == 1)
      begin
        hold_n = 1'b1;
        @(negedge sys_clk);
        check("hold_wdrive", 1'b1, doe_n);
        hold_n = 1'b0;
      end
    end
    issue(3'h6, 1'b0, 1'b1, 2'h3, a, 18'h0);
    if (stall)
    begin
      check("full", 1'b0, wready);
      stall = 1'b0;
    end
    for (int t = 0; t < 20 && i_mem.wr_q.size() < base + exp_q.size(); t++)
      @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    check("wr_count", exp_q.size(), i_mem.wr_q.size() - base);
    if (i_mem.wr_q.size() != base + exp_q.size())
      test_done();
    for (int j = 0; j < exp_q.size(); j++)
      check("wr_beat", exp_q[j], i_mem.wr_q[base + j]);
  endtask : wr_burst

  // ********************************************************
  // Tests
  // ********************************************************
  initial
  begin
    repeat (16) @(negedge sys_clk);
    check("rst_drive", 1'b1, doe_n);
    check("rst_rd", 1'b0, rd_en);
    rst_b = 1'b1;
    @(negedge sys_clk);
    check("rst_wv", 1'b0, wr_valid);
    check("rst_wr", 1'b1, wready);
    repeat (3) @(negedge sys_clk);
    $display("test reset done");
    for (int c = 0; c < 3; c++)
    begin
      issue(c == 0 ? 3'h6 : c == 1 ? 3'h3 : 3'h0, 1'b0, 1'b1, 2'h3, 21'h0, 18'h0);
      check("desel", 2'h1, {rd_en, doe_n});
      issue(3'h2, 1'b1, 1'b1, 2'h3, 21'h0, 18'h0);
      check("cont_desel", 2'h1, {rd_en, doe_n});
    end
    $display("test deselect done");
    wr_burst(21'h000106, 8'h72, 4, 4, 1'b1);
    $display("test write done");
    rd_burst(21'h000211, 5, 1'b1);
    $display("test read done");
    oe_n = 1'b1;
    rd_burst(21'h000302, 2, 1'b0);
    oe_n = 1'b0;
    $display("test dummy done");
    order = 1'b0;
    repeat (3) @(negedge sys_clk);
    rd_burst(21'h000403, 5, 1'b0);
    $display("test linear done");
    ft_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rd_burst(21'h000501, 3, 1'b0);
    $display("test flow done");
    stall = 1'b1;
    wr_burst(21'h000600, 8'h00, 3, 2, 1'b0);
    $display("test stall done");
    test_done();
  end
endmodule : tb
